// file: rtl/coa_operand_addr.sv
`timescale 1ns/1ps
// How it works
// RQ1 - direct mode: 8-bit instruction field addresses internal RAM or special registers
// RQ2 - 8-bit indirect: address read from bank pointer register zero or one
// RQ3 - 16-bit indirect: address is the data pointer
// RQ4 - register mode: opcode picks one of eight registers in the active bank
// RQ5 - implicit instructions route the accumulator (or B) as operand
// RQ6 - immediate mode: operand is the constant byte in the instruction
// RQ7 - indexed mode only reads program memory at data pointer plus accumulator
// RQ8 - bit instructions pick one bit of a 256-bit space
// RQ9 - arithmetic accepts direct, indirect, register, immediate, register-specific modes
// RQ10 - arithmetic does add, subtract, multiply, divide, increment, decrement
// RQ11 - most instructions finish in one or two cycles
// RQ12 - two-bit bank select from the status register picks the active bank
module coa_operand_addr
	import coa_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire logic [7:0] opcode,
	input wire logic [7:0] instr_byte1,
	input wire logic [15:0] data_pointer,
	input wire logic [1:0] bank_sel,
	input wire logic [7:0] mem_rdata,
	output logic instr_ready_ff,
	output logic mem_rd_ff,
	output logic mem_wr_ff,
	output coa_space_e mem_space_ff,
	output logic [15:0] mem_addr_ff,
	output logic [7:0] mem_wdata_ff,
	output logic [7:0] acc_ff,
	output logic [7:0] breg_ff,
	output logic carry_ff,
	output logic ov_ff,
	output logic done_ff,
	output logic illegal_ff,
	output coa_mode_e mode_ff
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// bank registers live in the low 32 bytes of internal RAM
	function automatic logic [15:0] coa_bank_addr(input logic [1:0] bank, input logic [2:0] idx);
		coa_bank_addr = {8'h00, 3'b000, bank, idx}; // [RQ4] [RQ12]
	endfunction : coa_bank_addr

	function automatic logic [15:0] coa_bit_byte(input logic [7:0] bit_addr);
		// low half maps to 16 RAM bytes, high half to every eighth special register
		if (bit_addr < SFR_BASE)
			coa_bit_byte = {8'h00, BIT_BYTE_BASE + {4'h0, bit_addr[6:3]}}; // [RQ8]
		else
			coa_bit_byte = {8'h00, bit_addr[7:3], 3'b000};
	endfunction : coa_bit_byte

	function automatic coa_dec_s coa_decode(input logic [7:0] opc);
		coa_dec_s d;
		logic grp;
		d.mode = MD_NONE;
		d.aop = AOP_PASS;
		grp = 1'b1;
		case (opc)
			OPC_MUL: d = '{MD_ACC, AOP_MUL}; // [RQ5] [RQ10]
			OPC_DIV: d = '{MD_ACC, AOP_DIV};
			OPC_MOVC: d = '{MD_INDEXED, AOP_PASS}; // [RQ7]
			OPC_XRD: d = '{MD_IND16, AOP_PASS}; // [RQ3]
			OPC_BIT_CPL: d = '{MD_BIT, AOP_BCPL}; // [RQ8]
			OPC_BIT_CLR: d = '{MD_BIT, AOP_BCLR};
			OPC_BIT_SET: d = '{MD_BIT, AOP_BSET};
			default:
			begin
				case (opc[7:4])
					OPC_GRP_INC: d.aop = AOP_INC; // [RQ10]
					OPC_GRP_DEC: d.aop = AOP_DEC;
					OPC_GRP_ADD: d.aop = AOP_ADD;
					OPC_GRP_ADDC: d.aop = AOP_ADDC;
					OPC_GRP_SUBB: d.aop = AOP_SUBB;
					default: grp = 1'b0;
				endcase
				// the low nibble picks the operand mode for the whole group [RQ9]
				if (grp && opc[3])
					d.mode = MD_REG;
				else if (grp && opc[3:0] == OPC_LO_IMM)
					d.mode = (d.aop == AOP_INC || d.aop == AOP_DEC) ? MD_ACC : MD_IMM;
				else if (grp && opc[3:0] == OPC_LO_DIR)
					d.mode = MD_DIRECT;
				else if (grp && (opc[3:0] == OPC_LO_IND0 || opc[3:0] == OPC_LO_IND1))
					d.mode = MD_IND8;
				else
					d = '{MD_NONE, AOP_PASS};
			end
		endcase
		coa_decode = d;
	endfunction : coa_decode

	// ------------------------------------------------------------
	// state and alu hookup
	// ------------------------------------------------------------
	coa_state_e state_ff, nxt_state;
	coa_aop_e aop_ff, nxt_aop;
	coa_mode_e nxt_mode;
	coa_space_e nxt_space;
	coa_dec_s dec;
	logic [7:0] opnd_ff, nxt_opnd, nxt_acc, nxt_breg, nxt_wdata;
	logic [2:0] bitsel_ff, nxt_bitsel;
	logic [15:0] nxt_addr;
	logic nxt_ready, nxt_rd, nxt_wr, nxt_carry, nxt_ov, nxt_done, nxt_illegal;
	logic accept;

	coa_alu_if alu_bus ();

	coa_alu u_alu (
		.alu(alu_bus.alu)
	);

	// operand comes straight from memory on a fetch, else from the latched byte
	assign alu_bus.a = acc_ff;
	assign alu_bus.b = (state_ff == ST_FETCH) ? mem_rdata : opnd_ff;
	assign alu_bus.op = aop_ff;
	assign alu_bus.bitsel = bitsel_ff;
	assign alu_bus.cin = carry_ff;
	assign accept = instr_valid && instr_ready_ff;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		dec = coa_decode(opcode);
		nxt_state = state_ff;
		nxt_aop = aop_ff;
		nxt_mode = mode_ff;
		nxt_space = mem_space_ff;
		nxt_addr = mem_addr_ff;
		nxt_opnd = opnd_ff;
		nxt_bitsel = bitsel_ff;
		nxt_acc = acc_ff;
		nxt_breg = breg_ff;
		nxt_carry = carry_ff;
		nxt_ov = ov_ff;
		nxt_wdata = mem_wdata_ff;
		nxt_ready = instr_ready_ff;
		nxt_rd = 1'b0;
		nxt_wr = 1'b0;
		nxt_done = 1'b0;
		nxt_illegal = 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				if (instr_valid)
				begin
					nxt_aop = dec.aop;
					nxt_mode = dec.mode;
					nxt_bitsel = instr_byte1[2:0];
					nxt_ready = 1'b0;
					nxt_rd = 1'b1;
					nxt_state = ST_FETCH;
					case (dec.mode)
						MD_DIRECT:
						begin
							nxt_space = (instr_byte1 < SFR_BASE) ? SP_IRAM : SP_SFR; // [RQ1]
							nxt_addr = {8'h00, instr_byte1};
						end
						MD_REG:
						begin
							nxt_space = SP_IRAM;
							nxt_addr = coa_bank_addr(bank_sel, opcode[2:0]); // [RQ4] [RQ12]
						end
						MD_IND8:
						begin
							// first read the pointer out of the bank [RQ2]
							nxt_space = SP_IRAM;
							nxt_addr = coa_bank_addr(bank_sel, {2'b00, opcode[0]});
							nxt_state = ST_PTR;
						end
						MD_IND16:
						begin
							nxt_space = SP_XDATA;
							nxt_addr = data_pointer; // [RQ3]
						end
						MD_INDEXED:
						begin
							nxt_space = SP_CODE;
							nxt_addr = data_pointer + {8'h00, acc_ff}; // [RQ7]
						end
						MD_BIT:
						begin
							nxt_space = (instr_byte1 < SFR_BASE) ? SP_IRAM : SP_SFR;
							nxt_addr = coa_bit_byte(instr_byte1); // [RQ8]
						end
						MD_IMM:
						begin
							nxt_rd = 1'b0;
							nxt_opnd = instr_byte1; // [RQ6]
							nxt_state = ST_EXEC;
						end
						MD_ACC:
						begin
							// multiply and divide take B, the rest the accumulator [RQ5]
							nxt_rd = 1'b0;
							nxt_opnd = (dec.aop == AOP_MUL || dec.aop == AOP_DIV) ? breg_ff : acc_ff;
							nxt_state = ST_EXEC;
						end
						default:
						begin
							nxt_rd = 1'b0;
							nxt_ready = 1'b1;
							nxt_done = 1'b1;
							nxt_illegal = 1'b1;
							nxt_state = ST_IDLE;
						end
					endcase
				end
			end
			ST_PTR:
			begin
				nxt_rd = 1'b1;
				nxt_addr = {8'h00, mem_rdata}; // [RQ2]
				nxt_state = ST_FETCH;
			end
			ST_FETCH, ST_EXEC:
			begin
				// commit in the same cycle the operand is seen [RQ11]
				nxt_done = 1'b1;
				nxt_ready = 1'b1;
				nxt_state = ST_IDLE;
				nxt_wdata = alu_bus.res;
				case (aop_ff)
					AOP_ADD, AOP_ADDC, AOP_SUBB:
					begin
						nxt_acc = alu_bus.res; // [RQ10]
						nxt_carry = alu_bus.cy;
						nxt_ov = alu_bus.ov;
					end
					AOP_MUL, AOP_DIV:
					begin
						nxt_acc = alu_bus.res;
						nxt_breg = alu_bus.res_hi;
						nxt_carry = alu_bus.cy;
						nxt_ov = alu_bus.ov;
					end
					AOP_INC, AOP_DEC:
					begin
						if (mode_ff == MD_ACC)
							nxt_acc = alu_bus.res; // [RQ5]
						else
							nxt_wr = 1'b1;
					end
					AOP_BCLR, AOP_BSET, AOP_BCPL: nxt_wr = 1'b1; // read-modify-write of the byte
					default: nxt_acc = alu_bus.res;
				endcase
			end
			default:
			begin
				nxt_state = ST_IDLE;
				nxt_ready = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_ff <= ST_IDLE;
			aop_ff <= AOP_PASS;
			mode_ff <= MD_NONE;
			mem_space_ff <= SP_IRAM;
			mem_addr_ff <= ADDR_RST;
			opnd_ff <= ACC_RST;
			bitsel_ff <= 3'h0;
			acc_ff <= ACC_RST;
			breg_ff <= BREG_RST;
			carry_ff <= 1'b0;
			ov_ff <= 1'b0;
			mem_wdata_ff <= ACC_RST;
			instr_ready_ff <= 1'b1;
			mem_rd_ff <= 1'b0;
			mem_wr_ff <= 1'b0;
			done_ff <= 1'b0;
			illegal_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			aop_ff <= nxt_aop;
			mode_ff <= nxt_mode;
			mem_space_ff <= nxt_space;
			mem_addr_ff <= nxt_addr;
			opnd_ff <= nxt_opnd;
			bitsel_ff <= nxt_bitsel;
			acc_ff <= nxt_acc;
			breg_ff <= nxt_breg;
			carry_ff <= nxt_carry;
			ov_ff <= nxt_ov;
			mem_wdata_ff <= nxt_wdata;
			instr_ready_ff <= nxt_ready;
			mem_rd_ff <= nxt_rd;
			mem_wr_ff <= nxt_wr;
			done_ff <= nxt_done;
			illegal_ff <= nxt_illegal;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_take(logic [7:0] opc_hit);
		accept && opcode == opc_hit;
	endsequence
	sequence s_take_mode(coa_mode_e m);
		accept && dec.mode == m;
	endsequence

	direct_addr_a: assert property (s_take_mode(MD_DIRECT) |=> mem_rd_ff // [RQ1]
		&& mem_addr_ff == {8'h00, $past(instr_byte1)} && mem_space_ff != SP_XDATA)
		else $error("direct operand address wrong");
	ind8_ptr_a: assert property (s_take_mode(MD_IND8) |=> state_ff == ST_PTR // [RQ2]
		&& mem_addr_ff[15:3] == {11'h000, $past(bank_sel)} && mem_addr_ff[2:1] == 2'b00
		##1 mem_rd_ff && mem_addr_ff == {8'h00, $past(mem_rdata)})
		else $error("indirect pointer not followed");
	ind16_a: assert property (s_take_mode(MD_IND16) |=> mem_space_ff == SP_XDATA // [RQ3]
		&& mem_addr_ff == $past(data_pointer))
		else $error("wide indirect address wrong");
	reg_bank_a: assert property (s_take_mode(MD_REG) |=> // [RQ4]
		mem_addr_ff == {11'h000, $past(bank_sel), $past(opcode[2:0])})
		else $error("bank register address wrong");
	bank_pick_a: assert property (accept && dec.mode == MD_REG && bank_sel == 2'b11 |=> // [RQ12]
		mem_addr_ff[4:3] == 2'b11)
		else $error("bank select ignored");
	acc_inc_a: assert property (s_take({OPC_GRP_INC, OPC_LO_IMM}) |=> !mem_rd_ff ##1 done_ff // [RQ5]
		&& acc_ff == $past(acc_ff, 2) + 8'h01)
		else $error("implicit accumulator increment wrong");
	imm_add_a: assert property (s_take({OPC_GRP_ADD, OPC_LO_IMM}) |=> !mem_rd_ff ##1 // [RQ6]
		acc_ff == $past(acc_ff, 2) + $past(instr_byte1, 2))
		else $error("immediate add wrong");
	indexed_rd_a: assert property (s_take(OPC_MOVC) |=> mem_space_ff == SP_CODE // [RQ7]
		&& mem_addr_ff == $past(data_pointer) + {8'h00, $past(acc_ff)} && !mem_wr_ff)
		else $error("indexed read address wrong");
	bit_set_a: assert property (s_take(OPC_BIT_SET) |=> ##1 mem_wr_ff // [RQ8]
		&& mem_wdata_ff == ($past(mem_rdata) | (8'h01 << bitsel_ff)))
		else $error("bit set wrong");
	arith_modes_a: assert property (accept && opcode[7:4] == OPC_GRP_ADD // [RQ9]
		&& opcode[3:0] >= OPC_LO_IMM |=> !illegal_ff)
		else $error("arithmetic mode refused");
	mul_res_a: assert property (s_take(OPC_MUL) |=> ##1 // [RQ10]
		{breg_ff, acc_ff} == 16'($past(acc_ff, 2)) * 16'($past(breg_ff, 2)))
		else $error("multiply result wrong");
	latency_a: assert property (accept |-> ##[1:3] done_ff) // [RQ11]
		else $error("instruction took too long");

endmodule : coa_operand_addr

// file: rtl/coa_pkg.sv
package coa_pkg;

	// ------------------------------------------------------------
	// opcode encodings
	// ------------------------------------------------------------
	localparam logic [3:0] OPC_GRP_INC = 4'h0;
	localparam logic [3:0] OPC_GRP_DEC = 4'h1;
	localparam logic [3:0] OPC_GRP_ADD = 4'h2;
	localparam logic [3:0] OPC_GRP_ADDC = 4'h3;
	localparam logic [3:0] OPC_GRP_SUBB = 4'h9;
	localparam logic [3:0] OPC_LO_IMM = 4'h4;
	localparam logic [3:0] OPC_LO_DIR = 4'h5;
	localparam logic [3:0] OPC_LO_IND0 = 4'h6;
	localparam logic [3:0] OPC_LO_IND1 = 4'h7;
	localparam logic [7:0] OPC_MUL = 8'ha4;
	localparam logic [7:0] OPC_DIV = 8'h84;
	localparam logic [7:0] OPC_MOVC = 8'h93;
	localparam logic [7:0] OPC_XRD = 8'he0;
	localparam logic [7:0] OPC_BIT_CPL = 8'hb2;
	localparam logic [7:0] OPC_BIT_CLR = 8'hc2;
	localparam logic [7:0] OPC_BIT_SET = 8'hd2;

	// ------------------------------------------------------------
	// address map and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SFR_BASE = 8'h80;
	localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] BREG_RST = 8'h00;
	localparam logic [15:0] ADDR_RST = 16'h0000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SP_IRAM, SP_SFR, SP_XDATA, SP_CODE} coa_space_e;
	typedef enum logic [3:0] {MD_NONE, MD_DIRECT, MD_IND8, MD_IND16, MD_REG, MD_ACC, MD_IMM,
		MD_INDEXED, MD_BIT} coa_mode_e;
	typedef enum logic [3:0] {AOP_PASS, AOP_ADD, AOP_ADDC, AOP_SUBB, AOP_INC, AOP_DEC, AOP_MUL,
		AOP_DIV, AOP_BCLR, AOP_BSET, AOP_BCPL} coa_aop_e;
	typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_FETCH, ST_EXEC} coa_state_e;
	typedef struct packed {
		coa_mode_e mode;
		coa_aop_e aop;
	} coa_dec_s;

endpackage : coa_pkg

// file: rtl/coa_alu_if.sv
`timescale 1ns/1ps
interface coa_alu_if;
	import coa_pkg::*;
	logic [7:0] a;
	logic [7:0] b;
	coa_aop_e op;
	logic [2:0] bitsel;
	logic cin;
	logic [7:0] res;
	logic [7:0] res_hi;
	logic cy;
	logic ov;
	modport core (output a, b, op, bitsel, cin, input res, res_hi, cy, ov);
	modport alu (input a, b, op, bitsel, cin, output res, res_hi, cy, ov);
endinterface : coa_alu_if

// file: rtl/coa_alu.sv
`timescale 1ns/1ps
module coa_alu
	import coa_pkg::*;
(
	coa_alu_if.alu alu
);

	logic [8:0] sum9;
	logic [8:0] dif9;
	logic [15:0] prod;

	// ------------------------------------------------------------
	// arithmetic and bit operations, purely combinational
	// ------------------------------------------------------------
	always_comb
	begin
		sum9 = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.cin && alu.op == AOP_ADDC};
		dif9 = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, alu.cin};
		prod = 16'(alu.a) * 16'(alu.b);
		alu.res = alu.b;
		alu.res_hi = 8'h00;
		alu.cy = alu.cin;
		alu.ov = 1'b0;
		case (alu.op)
			AOP_ADD, AOP_ADDC:
			begin
				alu.res = sum9[7:0];
				alu.cy = sum9[8];
				alu.ov = (alu.a[7] == alu.b[7]) && (sum9[7] != alu.a[7]);
			end
			AOP_SUBB:
			begin
				alu.res = dif9[7:0];
				alu.cy = dif9[8];
				alu.ov = (alu.a[7] != alu.b[7]) && (dif9[7] != alu.a[7]);
			end
			AOP_INC: alu.res = alu.b + 8'h01; // wraps, flags untouched
			AOP_DEC: alu.res = alu.b - 8'h01;
			AOP_MUL:
			begin
				alu.res = prod[7:0];
				alu.res_hi = prod[15:8];
				alu.cy = 1'b0;
				alu.ov = prod[15:8] != 8'h00;
			end
			AOP_DIV:
			begin
				// divide by zero flags overflow and returns all ones
				alu.cy = 1'b0;
				alu.ov = alu.b == 8'h00;
				alu.res = (alu.b == 8'h00) ? 8'hff : alu.a / alu.b;
				alu.res_hi = (alu.b == 8'h00) ? 8'hff : alu.a % alu.b;
			end
			AOP_BCLR: alu.res = alu.b & ~(8'h01 << alu.bitsel);
			AOP_BSET: alu.res = alu.b | (8'h01 << alu.bitsel);
			AOP_BCPL: alu.res = alu.b ^ (8'h01 << alu.bitsel);
			default: alu.res = alu.b;
		endcase
	end

endmodule : coa_alu

// file: verif/coa_mem_model.sv
`timescale 1ns/1ps
module coa_mem_model
	import coa_pkg::*;
(
	input wire logic clk,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire coa_space_e mem_space,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	// ------------------------------------------------------------
	// internal ram, special registers, far spaces
	// ------------------------------------------------------------
	logic [7:0] iram [256];
	logic [7:0] sfr [256];
	logic [7:0] idle_pat;

	// seeded contents, no two neighbours alike
	initial
	begin
		for (int i = 0; i < 256; i++)
		begin
			iram[i] = 8'(i * 5 + 27);
			sfr[i] = 8'(i) ^ 8'h5a;
		end
		idle_pat = 8'h00;
	end

	// write pulse lands on the edge; idle bus pattern moves every cycle
	always @(posedge clk)
	begin
		idle_pat <= idle_pat + 8'h35;
		if (mem_wr && mem_space == SP_SFR)
			sfr[mem_addr[7:0]] <= mem_wdata;
		else if (mem_wr)
			iram[mem_addr[7:0]] <= mem_wdata;
	end

	// same-cycle read data; garbage when no read so stale data is not trusted
	always_comb
	begin
		mem_rdata = idle_pat;
		if (mem_rd)
			case (mem_space)
				SP_IRAM: mem_rdata = iram[mem_addr[7:0]];
				SP_SFR: mem_rdata = sfr[mem_addr[7:0]];
				SP_XDATA: mem_rdata = mem_addr[7:0] + mem_addr[15:8];
				default: mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'ha5;
			endcase
	end
endmodule : coa_mem_model

// file: verif/cpu_operand_addressing_test.sv
`timescale 1ns/1ps
module cpu_operand_addressing_test
	import coa_pkg::*;
;
	logic clk, rstn, instr_valid, ecy;
	logic [7:0] opcode, instr_byte1, mem_rdata, mem_wdata_ff, acc_ff, breg_ff, ea, v;
	logic [15:0] data_pointer, mem_addr_ff, rd_a0, rd_a1, wr_a;
	logic [1:0] bank_sel;
	logic instr_ready_ff, mem_rd_ff, mem_wr_ff, carry_ff, ov_ff, done_ff, illegal_ff;
	logic [7:0] wr_d;
	coa_space_e mem_space_ff, rd_sp;
	coa_mode_e mode_ff;
	int err_count, n_checks, n_rd, cyc;

	coa_operand_addr DUT (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
		.opcode(opcode), .instr_byte1(instr_byte1), .data_pointer(data_pointer),
		.bank_sel(bank_sel), .mem_rdata(mem_rdata), .instr_ready_ff(instr_ready_ff),
		.mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff), .mem_space_ff(mem_space_ff),
		.mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .acc_ff(acc_ff),
		.breg_ff(breg_ff), .carry_ff(carry_ff), .ov_ff(ov_ff), .done_ff(done_ff),
		.illegal_ff(illegal_ff), .mode_ff(mode_ff));

	coa_mem_model PM (.clk(clk), .mem_rd(mem_rd_ff), .mem_wr(mem_wr_ff),
		.mem_space(mem_space_ff), .mem_addr(mem_addr_ff), .mem_wdata(mem_wdata_ff),
		.mem_rdata(mem_rdata));

	// ------------------------------------------------------------
	// clock, report, shared helpers
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// wide enough for space, address and data packed together
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one instruction, held until taken, then traced until done
	task automatic run(input logic [7:0] op, input logic [7:0] b1, input coa_mode_e md,
		input logic bad);
		int k;
		opcode = op;
		instr_byte1 = b1;
		instr_valid = 1'b1;
		for (k = 0; k < 10 && instr_ready_ff !== 1'b1; k++)
			@(negedge clk);
		@(negedge clk);
		instr_valid = 1'b0;
		n_rd = 0;
		rd_a0 = 'x;
		rd_a1 = 'x;
		wr_a = 'x;
		wr_d = 'x;
		for (cyc = 0; cyc < 8; cyc++)
		begin
			if (mem_rd_ff === 1'b1)
			begin
				if (n_rd == 0)
					rd_a0 = mem_addr_ff;
				rd_a1 = mem_addr_ff;
				rd_sp = mem_space_ff;
				n_rd++;
			end
			if (mem_wr_ff === 1'b1)
			begin
				wr_a = mem_addr_ff;
				wr_d = mem_wdata_ff;
			end
			if (done_ff === 1'b1)
				break;
			@(negedge clk);
		end
		if (k == 10 || cyc == 8)
		begin
			err_count++;
			$display("[ERR] %0t handshake timed out", $time);
			finish_test();
		end
		chk(cyc > 3, 1'b0);
		chk(illegal_ff, bad);
		if (md != MD_NONE)
			chk(mode_ff, md);
	endtask : run

	// expected accumulator and carry for one arithmetic step
	task automatic upd(input logic [3:0] g, input logic [7:0] x);
		logic [8:0] s;
		case (g)
			OPC_GRP_ADD: s = {1'b0, ea} + x;
			OPC_GRP_ADDC: s = {1'b0, ea} + x + ecy;
			OPC_GRP_SUBB: s = {1'b0, ea} - x - ecy;
			OPC_GRP_INC: s = {ecy, ea + 8'h01};
			default: s = {ecy, ea - 8'h01};
		endcase
		{ecy, ea} = s;
		chk(acc_ff, ea);
		chk(carry_ff, ecy);
	endtask : upd

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk(instr_ready_ff, 1'b1);
		chk({acc_ff, breg_ff}, 16'h0000);
		chk({mem_rd_ff, mem_wr_ff, done_ff}, 3'h0);
		chk(mode_ff, MD_NONE);
	endtask : t_reset

	task automatic t_muldiv();
		logic [7:0] ops [3] = '{OPC_DIV, OPC_MUL, OPC_DIV};
		logic [16:0] res [3] = '{17'h1ffff, 17'h1fe01, 17'h00100};
		for (int i = 0; i < 3; i++)
		begin
			run(ops[i], 8'h00, MD_ACC, 1'b0);
			chk({ov_ff, breg_ff, acc_ff}, res[i]);
		end
		ea = 8'h00;
	endtask : t_muldiv

	task automatic t_imm();
		logic [3:0] g [4] = '{OPC_GRP_ADD, OPC_GRP_ADD, OPC_GRP_ADDC, OPC_GRP_SUBB};
		logic [7:0] x [4] = '{8'h9c, 8'h80, 8'h10, 8'h30};
		for (int i = 0; i < 4; i++)
		begin
			run({g[i], OPC_LO_IMM}, x[i], MD_IMM, 1'b0);
			chk(n_rd != 0, 1'b0);
			upd(g[i], x[i]);
		end
	endtask : t_imm

	task automatic t_direct();
		v = PM.iram[8'h45];
		run({OPC_GRP_ADD, OPC_LO_DIR}, 8'h45, MD_DIRECT, 1'b0);
		chk(rd_a0, 16'h0045);
		chk(rd_sp, SP_IRAM);
		upd(OPC_GRP_ADD, v);
		v = PM.sfr[8'ha8];
		run({OPC_GRP_SUBB, OPC_LO_DIR}, 8'ha8, MD_DIRECT, 1'b0);
		chk(rd_a0, 16'h00a8);
		chk(rd_sp, SP_SFR);
		upd(OPC_GRP_SUBB, v);
	endtask : t_direct

	task automatic t_ind();
		logic [7:0] a, p;
		for (int i = 0; i < 2; i++)
		begin
			bank_sel = 2'(i + 1);
			a = {3'h0, bank_sel, 2'h0, 1'(i)};
			p = PM.iram[a];
			v = PM.iram[p];
			run({OPC_GRP_ADDC, OPC_LO_IND0 + 4'(i)}, 8'h00, MD_IND8, 1'b0);
			chk(rd_a0, {8'h00, a});
			chk(rd_a1, {8'h00, p});
			upd(OPC_GRP_ADDC, v);
		end
	endtask : t_ind

	task automatic t_reg();
		logic [7:0] a;
		for (int i = 0; i < 8; i++)
		begin
			bank_sel = 2'(i);
			a = {3'h0, 2'(i), 3'(i)};
			v = PM.iram[a];
			run({OPC_GRP_ADD, 4'h8 + 4'(i)}, 8'h00, MD_REG, 1'b0);
			chk(rd_a0, {8'h00, a});
			upd(OPC_GRP_ADD, v);
		end
	endtask : t_reg

	task automatic t_impl();
		run({OPC_GRP_INC, OPC_LO_IMM}, 8'h00, MD_ACC, 1'b0);
		chk(n_rd != 0, 1'b0);
		upd(OPC_GRP_INC, 8'h00);
		run({OPC_GRP_DEC, OPC_LO_IMM}, 8'h00, MD_ACC, 1'b0);
		upd(OPC_GRP_DEC, 8'h00);
	endtask : t_impl

	task automatic t_data_pointer();
		logic [15:0] xa;
		data_pointer = 16'h12f0;
		run({OPC_GRP_ADD, OPC_LO_IMM}, 8'h35, MD_IMM, 1'b0);
		upd(OPC_GRP_ADD, 8'h35);
		run(OPC_MOVC, 8'h00, MD_INDEXED, 1'b0);
		// the add may carry into the high byte, so model the full address
		xa = 16'h12f0 + 16'(ea);
		chk({rd_sp, rd_a1}, {SP_CODE, xa});
		ea = xa[7:0] ^ xa[15:8] ^ 8'ha5;
		chk(acc_ff, ea);
		run(OPC_XRD, 8'h00, MD_IND16, 1'b0);
		chk({rd_sp, rd_a1}, {SP_XDATA, 16'h12f0});
		ea = 8'h02;
		chk(acc_ff, ea);
	endtask : t_data_pointer

	task automatic t_bit();
		logic [7:0] ops [3] = '{OPC_BIT_SET, OPC_BIT_CLR, OPC_BIT_CPL};
		logic [7:0] bits [3] = '{8'h13, 8'h9d, 8'h07};
		logic [7:0] a, o, m, e [3];
		for (int i = 0; i < 3; i++)
		begin
			a = bits[i][7] ? {bits[i][7:3], 3'h0} : 8'h20 + bits[i][6:3];
			o = bits[i][7] ? PM.sfr[a] : PM.iram[a];
			m = 8'h01 << bits[i][2:0];
			e = '{o | m, o & ~m, o ^ m};
			run(ops[i], bits[i], MD_BIT, 1'b0);
			chk({rd_sp, rd_a0}, {bits[i][7] ? SP_SFR : SP_IRAM, 8'h00, a});
			chk(wr_a, {8'h00, a});
			chk(wr_d, e[i]);
		end
	endtask : t_bit

	task automatic t_memwr();
		logic [7:0] p, o;
		o = PM.iram[8'h30];
		run({OPC_GRP_INC, OPC_LO_DIR}, 8'h30, MD_DIRECT, 1'b0);
		chk({wr_a, wr_d}, {16'h0030, o + 8'h01});
		bank_sel = 2'h0;
		p = PM.iram[8'h00];
		o = PM.iram[p];
		run({OPC_GRP_DEC, OPC_LO_IND0}, 8'h00, MD_IND8, 1'b0);
		chk({wr_a, wr_d}, {8'h00, p, o - 8'h01});
		chk(acc_ff, ea);
		run(8'ha5, 8'h00, MD_NONE, 1'b1);
		chk(acc_ff, ea);
	endtask : t_memwr

	// reset, then every scenario back to back
	initial
	begin
		err_count = 0;
		n_checks = 0;
		rstn = 1'b0;
		instr_valid = 1'b0;
		opcode = 8'h00;
		instr_byte1 = 8'h00;
		data_pointer = 16'h0000;
		bank_sel = 2'h0;
		ea = 8'h00;
		ecy = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_muldiv();
		t_imm();
		t_direct();
		t_ind();
		t_reg();
		t_impl();
		t_data_pointer();
		t_bit();
		t_memwr();
		finish_test();
	end
endmodule : cpu_operand_addressing_test
